// ==== timer_capture_pkg.sv ====
// constants, register map and carrier types for the timer clock select and capture block
// Function
// (RULE1) mode 000: software-only control, update self-clears
// (RULE2) internal clock drives counting once run set
// (RULE3) mode 111 counts selected trigger edges
// (RULE4) source 110: channel 2 edge counts, sets flag
// (RULE5) pin edges resynchronised before counting
// (RULE6) select 01 uses own pin; filter 0000 off
// (RULE7) polarity 00 rising, 10 falling
// (RULE8) ext clock mode 2 counts trigger pin
// (RULE9) trigger pin filtered, then prescaled; 01 halves
// (RULE10) trigger polarity 0 detects rising edges
// (RULE11) channel: filter, edge select, prescale, capture
// (RULE12) active-high reference, polarity applied last
// (RULE13) bus sees preload; capture via shadow copy
// (RULE14) capture latches counter, sets flag, requests
// (RULE15) capture with flag set sets overcapture
// (RULE16) flag clears by zero write or read
// (RULE17) input channel value register is read-only
// (RULE18) filter 0011 needs eight stable samples
// (RULE19) input prescaler 00 captures every transition
// (RULE20) capture only while capture enable set
// (RULE21) software reads data before overcapture flag
// (RULE22) capture-generate bit raises flag and requests
// (RULE23) pwm input: cross select, source 101, reset
// (RULE24) reset mode trigger restarts counter
package timer_capture_pkg;
  // *****************************
  // register byte offsets
  // *****************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLAVE = 8'h04;
  localparam logic [7:0] OFS_IRQEN = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_EVENT = 8'h10;
  localparam logic [7:0] OFS_CHMODE = 8'h14;
  localparam logic [7:0] OFS_CHEN = 8'h18;
  localparam logic [7:0] OFS_CNT = 8'h1c;
  localparam logic [7:0] OFS_CCR1 = 8'h20;
  localparam logic [7:0] OFS_CCR2 = 8'h24;
  // *****************************
  // field positions
  // *****************************
  localparam int CTRL_RUN = 0;
  localparam int SM_MODE = 0;
  localparam int SM_TS = 4;
  localparam int SM_ETF = 8;
  localparam int SM_EXT_TRIGGER_PRESCALER = 12;
  localparam int SM_ECE = 14;
  localparam int SM_ETP = 15;
  localparam int DI_IE = 1;
  localparam int DI_DE = 9;
  localparam int SR_CCIF = 1;
  localparam int SR_TIF = 6;
  localparam int SR_CCOF = 9;
  localparam int EG_UG = 0;
  localparam int EG_CCG = 1;
  localparam int CM_SEL = 0;
  localparam int CM_PSC = 2;
  localparam int CM_FLT = 4;
  localparam int CM_STRIDE = 8;
  localparam int CE_EN = 0;
  localparam int CE_P = 1;
  localparam int CE_NP = 3;
  localparam int CE_STRIDE = 4;
  // *****************************
  // mode codes, counts, reset values
  // *****************************
  localparam logic [2:0] SMS_OFF = 3'h0;
  localparam logic [2:0] SMS_RESET = 3'h4;
  localparam logic [2:0] SMS_EXT1 = 3'h7;
  localparam logic [2:0] TS_TI1_EDGE = 3'h4;
  localparam logic [2:0] TS_CH1_FP1 = 3'h5;
  localparam logic [2:0] TS_CH2_FP2 = 3'h6;
  localparam logic [2:0] TS_EXT = 3'h7;
  localparam logic [1:0] SEL_OUT = 2'h0;
  localparam logic [1:0] SEL_OWN = 2'h1;
  localparam logic [1:0] SEL_CROSS = 2'h2;
  localparam logic [3:0] FLT_OFF = 4'h0;
  localparam logic [3:0] FLT_LEN1 = 4'h2;
  localparam logic [3:0] FLT_LEN2 = 4'h4;
  localparam logic [3:0] FLT_LEN3 = 4'h8;
  localparam logic [3:0] FLT_LEN_LONG = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] RST_REG = 16'h0000;
  // *****************************
  // carriers and state
  // *****************************
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } axi_req_s;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axi_rsp_s;
  typedef struct packed {
    logic [2:0] sync1; logic [2:0] sync2; logic [2:0] filt; logic [2:0] filt_d;
    logic [2:0][3:0] fcnt; logic [2:0] etr_div; logic [1:0][2:0] pcnt;
    logic [15:0] ctrl; logic [15:0] smcr; logic [15:0] dier; logic [15:0] sr;
    logic [15:0] ccmr; logic [15:0] ccer; logic [15:0] cnt;
    logic [1:0][15:0] pre; logic [1:0][15:0] shd; logic [1:0] cap_pend;
    logic aw_hold; logic [7:0] awaddr; logic w_hold; logic [31:0] wdata; logic [3:0] wstrb;
    axi_rsp_s bus; logic [1:0] ch_out; logic [1:0] irq; logic [1:0] dma;
  } state_s;
  localparam state_s ST_RESET = '0;
endpackage : timer_capture_pkg

// ==== timer_clock_select_and_capture.sv ====
// timer counter clock selection, input capture channels and register slave
`timescale 1ns/1ns
module timer_clock_select_and_capture (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire timer_capture_pkg::axi_req_s i_axi,
  output timer_capture_pkg::axi_rsp_s o_axi,
  input wire logic i_ch1_pin,
  input wire logic i_ch2_pin,
  input wire logic i_ext_trigger_pin,
  output logic [1:0] o_ch_out,
  output logic [1:0] o_capture_irq,
  output logic [1:0] o_capture_dma
);
  import timer_capture_pkg::*;

  state_s s_r;
  state_s s_nxt;
  logic [2:0] raw;
  logic [2:0] rise;
  logic [2:0] fall;
  logic fp1_ti1;
  logic fp2_ti1;
  logic fp1_ti2;
  logic fp2_ti2;
  logic etr_tick;
  logic trig;
  logic tick;
  logic ug;
  logic restart;
  logic do_wr;
  logic wr_ok;
  logic cnt_wr;
  logic [1:0] ccr_wr;
  logic [1:0] ccr_rd;
  logic [1:0] cap_hit;
  logic [1:0] ccg;
  logic [15:0] sr_set;
  logic [15:0] sr_clr;
  logic [15:0] wval;
  logic [7:0] ra;

  // *****************************
  // helpers
  // *****************************
  // byte-lane merge of a bus write into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
    lane_merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction : lane_merge

  // sample count a new level must hold; longer codes fall back to the longest length
  function automatic logic [3:0] filt_len(input logic [3:0] f);
    unique case (f)
      4'h1: filt_len = FLT_LEN1;
      4'h2: filt_len = FLT_LEN2;
      4'h3: filt_len = FLT_LEN3; // RULE18
      default: filt_len = FLT_LEN_LONG;
    endcase
  endfunction : filt_len

  // edge select: 00 rising, 10 falling, 11 both, 01 treated as rising
  function automatic logic edge_pick(input logic r, input logic fl, input logic p, input logic np);
    edge_pick = p ? (fl | (np & r)) : r; // RULE7
  endfunction : edge_pick

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_CCR2);
  endfunction : mapped

  // *****************************
  // next-state logic
  // *****************************
  always_comb
  begin
    s_nxt = s_r;
    raw = '0;
    rise = '0;
    fall = '0;
    etr_tick = 1'b0;
    trig = 1'b0;
    tick = 1'b0;
    ug = 1'b0;
    restart = 1'b0;
    cnt_wr = 1'b0;
    ccr_wr = '0;
    ccr_rd = '0;
    cap_hit = '0;
    ccg = '0;
    sr_set = '0;
    sr_clr = '0;
    wval = '0;
    ra = i_axi.araddr;
    s_nxt.dma = '0;

    // two-stage resync of the three pins; only stage two is read
    s_nxt.sync1 = {i_ext_trigger_pin, i_ch2_pin, i_ch1_pin}; // RULE5
    s_nxt.sync2 = s_r.sync1;
    raw = s_r.sync2 ^ {s_r.smcr[SM_ETP], 2'b00}; // RULE10

    // digital filters, sampled every core clock
    for (int i = 0; i < 3; i++)
    begin
      logic [3:0] fld;
      fld = (i == 2) ? s_r.smcr[SM_ETF +: 4] : s_r.ccmr[CM_FLT + i * CM_STRIDE +: 4];
      if (fld == FLT_OFF)
      begin
        s_nxt.filt[i] = raw[i]; // RULE6 RULE9
        s_nxt.fcnt[i] = '0;
      end
      else if (raw[i] == s_r.filt[i])
      begin
        s_nxt.fcnt[i] = '0;
      end
      else if (s_r.fcnt[i] + 4'h1 >= filt_len(fld))
      begin
        s_nxt.filt[i] = raw[i]; // RULE18
        s_nxt.fcnt[i] = '0;
      end
      else
      begin
        s_nxt.fcnt[i] = s_r.fcnt[i] + 4'h1;
      end
    end
    s_nxt.filt_d = s_r.filt;
    rise = s_r.filt & ~s_r.filt_d;
    fall = ~s_r.filt & s_r.filt_d;

    // polarity-selected edges of each filtered channel input
    fp1_ti1 = edge_pick(rise[0], fall[0], s_r.ccer[CE_P], s_r.ccer[CE_NP]); // RULE11
    fp2_ti1 = edge_pick(rise[0], fall[0], s_r.ccer[CE_P + CE_STRIDE], s_r.ccer[CE_NP + CE_STRIDE]);
    fp1_ti2 = edge_pick(rise[1], fall[1], s_r.ccer[CE_P], s_r.ccer[CE_NP]);
    fp2_ti2 = edge_pick(rise[1], fall[1], s_r.ccer[CE_P + CE_STRIDE], s_r.ccer[CE_NP + CE_STRIDE]);

    // trigger pin prescaler divides rising edges by 1, 2, 4 or 8
    if (rise[2])
    begin
      if (s_r.etr_div == 3'((4'h1 << s_r.smcr[SM_EXT_TRIGGER_PRESCALER +: 2]) - 4'h1))
      begin
        etr_tick = 1'b1; // RULE9
        s_nxt.etr_div = '0;
      end
      else
      begin
        s_nxt.etr_div = s_r.etr_div + 3'h1;
      end
    end

    // trigger selection; internal trigger codes have no source here
    unique case (s_r.smcr[SM_TS +: 3])
      TS_TI1_EDGE: trig = rise[0] | fall[0];
      TS_CH1_FP1: trig = fp1_ti1; // RULE23
      TS_CH2_FP2: trig = fp2_ti2; // RULE4
      TS_EXT: trig = rise[2];
      default: trig = 1'b0;
    endcase
    if (trig && s_r.smcr[SM_MODE +: 3] != SMS_OFF)
    begin
      sr_set[SR_TIF] = 1'b1; // RULE4
    end

    // counter clock source
    if (s_r.ctrl[CTRL_RUN])
    begin
      if (s_r.smcr[SM_MODE +: 3] == SMS_EXT1)
      begin
        tick = trig; // RULE3 RULE4
      end
      else if (s_r.smcr[SM_ECE])
      begin
        tick = etr_tick; // RULE8
      end
      else
      begin
        tick = 1'b1; // RULE2
      end
    end
    restart = trig && s_r.smcr[SM_MODE +: 3] == SMS_RESET; // RULE24

    // register bus: address and data held until both are present
    if (i_axi.awvalid && s_r.bus.awready)
    begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.awaddr = i_axi.awaddr;
    end
    if (i_axi.wvalid && s_r.bus.wready)
    begin
      s_nxt.w_hold = 1'b1;
      s_nxt.wdata = i_axi.wdata;
      s_nxt.wstrb = i_axi.wstrb;
    end
    if (s_r.bus.bvalid && i_axi.bready)
    begin
      s_nxt.bus.bvalid = 1'b0;
    end
    do_wr = s_r.aw_hold && s_r.w_hold && !s_r.bus.bvalid;
    wr_ok = do_wr && mapped(s_r.awaddr);
    if (do_wr)
    begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bus.bvalid = 1'b1;
      s_nxt.bus.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_ok)
    begin
      unique case (s_r.awaddr)
        OFS_CTRL: s_nxt.ctrl = lane_merge(s_r.ctrl, s_r.wdata, s_r.wstrb); // RULE1
        OFS_SLAVE: s_nxt.smcr = lane_merge(s_r.smcr, s_r.wdata, s_r.wstrb);
        OFS_IRQEN: s_nxt.dier = lane_merge(s_r.dier, s_r.wdata, s_r.wstrb);
        OFS_STATUS: sr_clr = ~lane_merge(16'hffff, s_r.wdata, s_r.wstrb); // RULE16
        OFS_EVENT:
        begin
          wval = lane_merge(RST_REG, s_r.wdata, s_r.wstrb);
          ug = wval[EG_UG]; // RULE1
          ccg = wval[EG_CCG +: 2];
        end
        OFS_CHMODE: s_nxt.ccmr = lane_merge(s_r.ccmr, s_r.wdata, s_r.wstrb);
        OFS_CHEN: s_nxt.ccer = lane_merge(s_r.ccer, s_r.wdata, s_r.wstrb);
        OFS_CNT: cnt_wr = 1'b1;
        OFS_CCR1: ccr_wr[0] = 1'b1;
        OFS_CCR2: ccr_wr[1] = 1'b1;
        default: ;
      endcase
    end

    // read side; a read of a value register also clears its capture flag
    if (s_r.bus.rvalid && i_axi.rready)
    begin
      s_nxt.bus.rvalid = 1'b0;
    end
    if (i_axi.arvalid && s_r.bus.arready)
    begin
      s_nxt.bus.rvalid = 1'b1;
      s_nxt.bus.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      s_nxt.bus.rdata = '0;
      unique case (ra)
        OFS_CTRL: s_nxt.bus.rdata[15:0] = s_r.ctrl;
        OFS_SLAVE: s_nxt.bus.rdata[15:0] = s_r.smcr;
        OFS_IRQEN: s_nxt.bus.rdata[15:0] = s_r.dier;
        OFS_STATUS: s_nxt.bus.rdata[15:0] = s_r.sr;
        OFS_CHMODE: s_nxt.bus.rdata[15:0] = s_r.ccmr;
        OFS_CHEN: s_nxt.bus.rdata[15:0] = s_r.ccer;
        OFS_CNT: s_nxt.bus.rdata[15:0] = s_r.cnt;
        OFS_CCR1: ccr_rd[0] = 1'b1;
        OFS_CCR2: ccr_rd[1] = 1'b1;
        default: ;
      endcase
      if (ccr_rd[0])
      begin
        s_nxt.bus.rdata[15:0] = s_r.pre[0]; // RULE13
      end
      if (ccr_rd[1])
      begin
        s_nxt.bus.rdata[15:0] = s_r.pre[1];
      end
    end
    sr_clr[SR_CCIF +: 2] = sr_clr[SR_CCIF +: 2] | ccr_rd; // RULE16

    // counter: update and reset-mode restart beat a write, which beats a tick
    if (ug || restart)
    begin
      s_nxt.cnt = RST_REG; // RULE1 RULE24
      s_nxt.etr_div = '0;
    end
    else if (cnt_wr)
    begin
      s_nxt.cnt = lane_merge(s_r.cnt, s_r.wdata, s_r.wstrb);
    end
    else if (tick)
    begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end

    // capture channels
    for (int i = 0; i < 2; i++)
    begin
      logic [1:0] sel;
      logic src;
      logic en;
      sel = s_r.ccmr[CM_SEL + i * CM_STRIDE +: 2];
      en = s_r.ccer[CE_EN + i * CE_STRIDE];
      src = 1'b0;
      if (sel == SEL_OWN)
      begin
        src = (i == 0) ? fp1_ti1 : fp2_ti2; // RULE6
      end
      else if (sel == SEL_CROSS)
      begin
        src = (i == 0) ? fp1_ti2 : fp2_ti1; // RULE23
      end
      // input prescaler counts edges; code 00 passes every edge
      if (!en || sel == SEL_OUT || ug)
      begin
        s_nxt.pcnt[i] = '0;
      end
      else if (src)
      begin
        if (s_r.pcnt[i] == 3'((4'h1 << s_r.ccmr[CM_PSC + i * CM_STRIDE +: 2]) - 4'h1))
        begin
          cap_hit[i] = 1'b1; // RULE19 RULE20
          s_nxt.pcnt[i] = '0;
        end
        else
        begin
          s_nxt.pcnt[i] = s_r.pcnt[i] + 3'h1;
        end
      end
      // capture lands in the shadow, moves to the preload one cycle later
      s_nxt.cap_pend[i] = cap_hit[i];
      if (cap_hit[i])
      begin
        s_nxt.shd[i] = s_r.cnt; // RULE13 RULE14 RULE24
      end
      if (s_r.cap_pend[i])
      begin
        s_nxt.pre[i] = s_r.shd[i]; // RULE13
        sr_set[SR_CCIF + i] = 1'b1; // RULE14
        sr_set[SR_CCOF + i] = s_r.sr[SR_CCIF + i]; // RULE15
      end
      // output channels: writable preload, shadow reloaded on update
      if (ccr_wr[i] && sel == SEL_OUT)
      begin
        s_nxt.pre[i] = lane_merge(s_r.pre[i], s_r.wdata, s_r.wstrb); // RULE17
      end
      if (sel == SEL_OUT && (ug || restart))
      begin
        s_nxt.shd[i] = s_r.pre[i]; // RULE13
      end
      if (ccg[i])
      begin
        sr_set[SR_CCIF + i] = 1'b1; // RULE22
      end
      s_nxt.dma[i] = (s_r.cap_pend[i] || ccg[i]) && s_r.dier[DI_DE + i]; // RULE14 RULE22
      // reference is high while counter below shadow; polarity flips it at the pin
      s_nxt.ch_out[i] = en && sel == SEL_OUT &&
                        ((s_r.cnt < s_r.shd[i]) ^ s_r.ccer[CE_P + i * CE_STRIDE]); // RULE12
    end

    // flags: a set in the same cycle as a clear wins
    s_nxt.sr = (s_r.sr & ~sr_clr) | sr_set; // RULE15 RULE16
    for (int i = 0; i < 2; i++)
    begin
      s_nxt.irq[i] = s_nxt.sr[SR_CCIF + i] && s_r.dier[DI_IE + i]; // RULE14
    end

    // write ready terms follow the holds and read ready follows rvalid, so each channel takes one item per transfer
    s_nxt.bus.awready = !s_nxt.aw_hold && !s_nxt.bus.bvalid;
    s_nxt.bus.wready = !s_nxt.w_hold && !s_nxt.bus.bvalid;
    s_nxt.bus.arready = !s_nxt.bus.rvalid;
  end

  // *****************************
  // state register
  // *****************************
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r <= ST_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_axi = s_r.bus;
  assign o_ch_out = s_r.ch_out;
  assign o_capture_irq = s_r.irq;
  assign o_capture_dma = s_r.dma;

  // *****************************
  // assertions
  // *****************************
  property p_update_restart;
    @(posedge i_core_clk) disable iff (i_rst)
    ug |=> (s_r.cnt == 16'h0000);
  endproperty
  a_update_restart: assert property (p_update_restart) else $error("update did not restart counter"); // RULE1

  property p_internal_count;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_r.ctrl[CTRL_RUN] && s_r.smcr[2:0] == SMS_OFF && !s_r.smcr[SM_ECE] && !ug && !cnt_wr)
      |=> (s_r.cnt == $past(s_r.cnt) + 16'h0001);
  endproperty
  a_internal_count: assert property (p_internal_count) else $error("internal clock did not count"); // RULE2

  property p_capture_commit;
    @(posedge i_core_clk) disable iff (i_rst)
    cap_hit[0] |=> ##1 (s_r.pre[0] == $past(s_r.cnt, 2) && s_r.sr[SR_CCIF]);
  endproperty
  a_capture_commit: assert property (p_capture_commit) else $error("capture value or flag missing"); // RULE14

  property p_overcapture;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_r.cap_pend[1] && s_r.sr[SR_CCIF + 1]) |=> s_r.sr[SR_CCOF + 1];
  endproperty
  a_overcapture: assert property (p_overcapture) else $error("overcapture flag not set"); // RULE15

  property p_read_clears;
    @(posedge i_core_clk) disable iff (i_rst)
    (ccr_rd[0] && !s_r.cap_pend[0] && !ccg[0]) |=> !s_r.sr[SR_CCIF];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("value read left capture flag set"); // RULE16

  property p_input_read_only;
    @(posedge i_core_clk) disable iff (i_rst)
    (ccr_wr[1] && s_r.ccmr[CM_SEL + CM_STRIDE +: 2] != SEL_OUT && !s_r.cap_pend[1]) |=> $stable(s_r.pre[1]);
  endproperty
  a_input_read_only: assert property (p_input_read_only) else $error("input channel value was written"); // RULE17

  property p_filter_length;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_r.ccmr[CM_FLT +: 4] == 4'h3 && $changed(s_r.ccmr[CM_FLT +: 4]) == 1'b0 && s_r.filt[0] != s_nxt.filt[0])
      |-> (s_r.fcnt[0] == 4'h7);
  endproperty
  a_filter_length: assert property (p_filter_length) else $error("filter accepted early"); // RULE18

  property p_no_capture_disabled;
    @(posedge i_core_clk) disable iff (i_rst)
    !s_r.ccer[CE_EN] |-> !cap_hit[0];
  endproperty
  a_no_capture_disabled: assert property (p_no_capture_disabled) else $error("capture while disabled"); // RULE20

  property p_trigger_flag;
    @(posedge i_core_clk) disable iff (i_rst)
    (trig && s_r.smcr[2:0] == SMS_EXT1) |=> s_r.sr[SR_TIF];
  endproperty
  a_trigger_flag: assert property (p_trigger_flag) else $error("trigger flag not set"); // RULE4
endmodule : timer_clock_select_and_capture

// ==== timer_pin_source.sv ====
// external signal source model for the timer channel and trigger pins
`timescale 1ns/1ns
module timer_pin_source (
  input wire logic i_core_clk,
  output logic o_ch1_pin,
  output logic o_ch2_pin,
  output logic o_ext_trigger_pin
);
  logic [2:0] lvl = 3'h0;
  // pins are always driven; levels change just after a clock edge so widths are exact
  assign o_ch1_pin = lvl[0];
  assign o_ch2_pin = lvl[1];
  assign o_ext_trigger_pin = lvl[2];
  // hold one pin at a level for a number of clocks; caller stands just after an edge
  task automatic drive(input int which, input logic level, input int cycles);
    lvl[which] <= level;
    repeat (cycles) @(posedge i_core_clk);
  endtask : drive
  // one pulse: high for hi clocks, then low for lo clocks
  task automatic pulse(input int which, input int hi, input int lo);
    drive(which, 1'b1, hi);
    drive(which, 1'b0, lo);
  endtask : pulse
endmodule : timer_pin_source

// ==== timer_clock_select_and_capture_bench.sv ====
// self-checking bench for the timer clock select and capture block
`timescale 1ns/1ns
module timer_clock_select_and_capture_bench;
  import timer_capture_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  axi_req_s axi = '0;
  axi_rsp_s rsp;
  logic ch1_pin;
  logic ch2_pin;
  logic ext_pin;
  logic [1:0] ch_out;
  logic [1:0] irq;
  logic [1:0] dma;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int dma_seen = 0;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  // 100 ns period
  always #50 i_core_clk = ~i_core_clk;
  timer_clock_select_and_capture timer_clock_select_and_capture_inst (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_axi(axi),
    .o_axi(rsp),
    .i_ch1_pin(ch1_pin),
    .i_ch2_pin(ch2_pin),
    .i_ext_trigger_pin(ext_pin),
    .o_ch_out(ch_out),
    .o_capture_irq(irq),
    .o_capture_dma(dma)
  );
  timer_pin_source timer_pin_source_inst (
    .i_core_clk(i_core_clk),
    .o_ch1_pin(ch1_pin),
    .o_ch2_pin(ch2_pin),
    .o_ext_trigger_pin(ext_pin)
  );
  // *****************************
  // bus and report tasks
  // *****************************
  task automatic complete_run;
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // ready is looked at on the falling edge, so the value seen is the one the next rising edge samples
  task automatic wr(input logic [7:0] addr, input logic [15:0] data, input logic [1:0] resp);
    logic a_left;
    logic w_left;
    logic a_go;
    logic w_go;
    logic [1:0] got;
    a_left = 1'b1;
    w_left = 1'b1;
    @(posedge i_core_clk);
    axi.awaddr <= addr;
    axi.wdata <= {16'h0000, data};
    axi.wstrb <= 4'hf;
    axi.awvalid <= 1'b1;
    axi.wvalid <= 1'b1;
    axi.bready <= 1'b1;
    while (a_left || w_left)
    begin
      @(negedge i_core_clk);
      a_go = a_left & (rsp.awready === 1'b1);
      w_go = w_left & (rsp.wready === 1'b1);
      @(posedge i_core_clk);
      if (a_go)
        axi.awvalid <= 1'b0;
      if (w_go)
        axi.wvalid <= 1'b0;
      a_left = a_left & ~a_go;
      w_left = w_left & ~w_go;
    end
    do @(negedge i_core_clk); while (rsp.bvalid !== 1'b1);
    got = rsp.bresp;
    @(posedge i_core_clk);
    axi.bready <= 1'b0;
    check($sformatf("write response %h", addr), {resp, 32'h0}, {got, 32'h0});
  endtask : wr
  task automatic rd(input logic [7:0] addr);
    @(posedge i_core_clk);
    axi.araddr <= addr;
    axi.arvalid <= 1'b1;
    axi.rready <= 1'b1;
    do @(negedge i_core_clk); while (rsp.arready !== 1'b1);
    @(posedge i_core_clk);
    axi.arvalid <= 1'b0;
    do @(negedge i_core_clk); while (rsp.rvalid !== 1'b1);
    rd_data = rsp.rdata;
    rd_resp = rsp.rresp;
    @(posedge i_core_clk);
    axi.rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] addr, input logic [15:0] exp);
    rd(addr);
    check($sformatf("register %h", addr), {RESP_OKAY, 16'h0000, exp}, {rd_resp, rd_data});
  endtask : rdc
  // hang guard: the whole sequence needs well under a thousand clocks
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end
  // dma requests are one-clock pulses; count them mid-cycle while they stand
  always @(negedge i_core_clk)
  begin
    if (dma[0] === 1'b1)
      dma_seen <= dma_seen + 1;
  end
  // *****************************
  // test sequence
  // *****************************
  initial
  begin
    logic [15:0] held;
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    // reset values, unmapped and unaligned places
    rdc(OFS_SLAVE, 16'h0000);
    rdc(OFS_CHMODE, 16'h0000);
    rd(8'h28);
    check("unmapped read response", {RESP_SLVERR, 32'h0}, {rd_resp, 32'h0});
    wr(8'h2a, 16'h1234, RESP_SLVERR);
    // internal clock runs only while the run bit is set
    wr(OFS_CTRL, 16'h0001, RESP_OKAY);
    wr(OFS_CTRL, 16'h0000, RESP_OKAY);
    rd(OFS_CNT);
    held = rd_data[15:0];
    check("counter ran", 34'h1, {33'h0, held != 16'h0000});
    repeat (10) @(posedge i_core_clk);
    rdc(OFS_CNT, held);
    wr(OFS_EVENT, 16'h0001, RESP_OKAY);
    rdc(OFS_CNT, 16'h0000);
    rdc(OFS_EVENT, 16'h0000);
    // counting edges of the channel 2 pin
    wr(OFS_CHMODE, 16'h0100, RESP_OKAY);
    wr(OFS_SLAVE, 16'h0067, RESP_OKAY);
    wr(OFS_CTRL, 16'h0001, RESP_OKAY);
    timer_pin_source_inst.drive(1, 1'b1, 8);
    rdc(OFS_CNT, 16'h0001);
    rdc(OFS_STATUS, 16'h0040);
    wr(OFS_CHEN, 16'h0020, RESP_OKAY);
    timer_pin_source_inst.drive(1, 1'b0, 8);
    rdc(OFS_CNT, 16'h0002);
    timer_pin_source_inst.drive(1, 1'b1, 8);
    rdc(OFS_CNT, 16'h0002);
    // trigger pin, no filter, halved
    wr(OFS_SLAVE, 16'h5000, RESP_OKAY);
    wr(OFS_CNT, 16'h0000, RESP_OKAY);
    repeat (4) timer_pin_source_inst.pulse(2, 3, 3);
    rdc(OFS_CNT, 16'h0002);
    // trigger pin as mode 1 source: every rising edge counts, prescaler bypassed
    wr(OFS_SLAVE, 16'h0077, RESP_OKAY);
    wr(OFS_CNT, 16'h0000, RESP_OKAY);
    repeat (2) timer_pin_source_inst.pulse(2, 3, 3);
    rdc(OFS_CNT, 16'h0002);
    // capture on a frozen counter so the latched value is known
    wr(OFS_SLAVE, 16'h0000, RESP_OKAY);
    wr(OFS_CTRL, 16'h0000, RESP_OKAY);
    wr(OFS_STATUS, 16'h0000, RESP_OKAY);
    wr(OFS_CNT, 16'h1234, RESP_OKAY);
    wr(OFS_CHMODE, 16'h0001, RESP_OKAY);
    wr(OFS_CHEN, 16'h0001, RESP_OKAY);
    wr(OFS_IRQEN, 16'h0202, RESP_OKAY);
    timer_pin_source_inst.pulse(0, 4, 4);
    rdc(OFS_CCR1, 16'h1234);
    rdc(OFS_STATUS, 16'h0000);
    timer_pin_source_inst.pulse(0, 4, 4);
    @(negedge i_core_clk);
    check("capture irq", 34'h1, {33'h0, irq[0]});
    wr(OFS_CNT, 16'h0055, RESP_OKAY);
    timer_pin_source_inst.pulse(0, 4, 4);
    rdc(OFS_CCR1, 16'h0055);
    rdc(OFS_STATUS, 16'h0200);
    wr(OFS_STATUS, 16'h0000, RESP_OKAY);
    rdc(OFS_STATUS, 16'h0000);
    @(negedge i_core_clk);
    check("capture irq", 34'h0, {33'h0, irq[0]});
    wr(OFS_CCR1, 16'habcd, RESP_OKAY);
    rdc(OFS_CCR1, 16'h0055);
    wr(OFS_CHEN, 16'h0000, RESP_OKAY);
    timer_pin_source_inst.pulse(0, 4, 4);
    rdc(OFS_STATUS, 16'h0000);
    wr(OFS_EVENT, 16'h0002, RESP_OKAY);
    rdc(OFS_STATUS, 16'h0002);
    // eight-sample filter: seven clocks rejected, nine accepted
    wr(OFS_STATUS, 16'h0000, RESP_OKAY);
    wr(OFS_CHMODE, 16'h0031, RESP_OKAY);
    wr(OFS_CHEN, 16'h0001, RESP_OKAY);
    timer_pin_source_inst.pulse(0, 7, 12);
    rdc(OFS_STATUS, 16'h0000);
    timer_pin_source_inst.pulse(0, 9, 12);
    rdc(OFS_STATUS, 16'h0002);
    // output reference: counter 0 below 0x10, polarity applied last
    wr(OFS_CHMODE, 16'h0000, RESP_OKAY);
    wr(OFS_CCR1, 16'h0010, RESP_OKAY);
    wr(OFS_EVENT, 16'h0001, RESP_OKAY);
    @(negedge i_core_clk);
    check("output reference", 34'h1, {33'h0, ch_out[0]});
    wr(OFS_CHEN, 16'h0003, RESP_OKAY);
    @(negedge i_core_clk);
    check("output inverted", 34'h0, {33'h0, ch_out[0]});
    // pwm input: period 40 clocks, high 10 clocks
    wr(OFS_CHMODE, 16'h0201, RESP_OKAY);
    wr(OFS_CHEN, 16'h0031, RESP_OKAY);
    wr(OFS_SLAVE, 16'h0054, RESP_OKAY);
    wr(OFS_CTRL, 16'h0001, RESP_OKAY);
    repeat (3) timer_pin_source_inst.pulse(0, 10, 30);
    rdc(OFS_CCR1, 16'h0027);
    wr(OFS_CCR2, 16'hbeef, RESP_OKAY);
    rdc(OFS_CCR2, 16'h0009);
    // ch1 commits: three frozen captures, one generate, one filtered, three pwm periods
    check("dma requests", 34'h8, 34'(dma_seen));
    complete_run();
  end
endmodule : timer_clock_select_and_capture_bench
